/* File: mcs_pin_sync.sv */
// three-stage synchroniser for one asynchronous level input
// assumes the pin may change at any time relative to ref_clk
`timescale 1ns/1ps
module mcs_pin_sync
   import mcs_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic reset_n,
   input  wire logic pin,
   output logic      level
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } mcs_sync_state_type;

   mcs_sync_state_type st_q;
   mcs_sync_state_type st_d;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      st_d    = st_q;
      st_d.s1 = pin;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      // only a value seen on two later stages counts
      if (st_q.s2 == st_q.s3)
      begin
         st_d.level = st_q.s3;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign level = st_q.level;

endmodule

/* File: mcs_pkg.sv */
// constants, carriers and helpers for the metering control/status registers
// assumes a 32-bit APB master and one 20 MHz clock domain
package mcs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bus shape
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W  = 10;

   ////////////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_SYSTEM_CONTROL_STATUS  = 10'h180;
   localparam logic [IDX_W-1:0] IDX_ANA0     = 10'h185;
   localparam logic [IDX_W-1:0] IDX_CHECKSUM = 10'h1a0;
   localparam logic [IDX_W-1:0] IDX_DETCFG   = 10'h1a1;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h1b0;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLR  = 10'h1b1;
   localparam logic [IDX_W-1:0] IDX_IRQ_EN   = 10'h1b2;

   ////////////////////////////////////////////////////////////////////////////
   // system control/status fields
   localparam int SC_SIGN_BIT   = 17;
   localparam int SC_DETECT_BIT = 18;
   localparam int SC_CONFIG_CHECKSUM_ERROR_BIT = 19;
   localparam int SC_SELFCHECK_ERROR_BIT = 20;
   localparam int SC_FIELD_W    = 9;
   localparam int SC_LOW_LSB    = 0;
   localparam int SC_MIRROR_LSB = 16;

   // analog control 0 fields
   localparam int ANA_RC_PD_BIT = 29;
   localparam int ANA_BIAS_BIT  = 28;
   localparam int ANA_BG_BIT    = 27;
   localparam int ANA_VADC_BIT  = 26;

   // detector configuration fields
   localparam int DET_THR_LSB = 0;
   localparam int DET_THR_W   = 16;
   localparam int DET_RUN_LSB = 16;
   localparam int DET_RUN_W   = 8;

   // interrupt status bits
   localparam int IRQ_W          = 3;
   localparam int IRQ_DETECT_BIT = 0;
   localparam int IRQ_CONFIG_CHECKSUM_ERROR_BIT = 1;
   localparam int IRQ_SELFCHECK_ERROR_BIT = 2;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and check constant
   localparam logic [31:0] SYSTEM_CONTROL_STATUS_RESET  = 32'h0000_0000;
   localparam logic [31:0] ANA0_RESET     = 32'h2000_0000;
   localparam logic [31:0] CHECKSUM_RESET = 32'h0000_0000;
   localparam logic [31:0] DETCFG_RESET   = 32'h0004_0100;
   localparam logic [31:0] CHKSUM_PASS    = 32'hffff_ffff;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } mcs_apb_req_type;

   typedef struct packed {
      logic              pready;
      logic              pslverr;
      logic [DATA_W-1:0] prdata;
   } mcs_apb_rsp_type;

   typedef struct packed {
      logic rc_osc_powerdown;
      logic bias_circuit_enable;
      logic bandgap_enable;
      logic voltage_adc_enable;
   } mcs_pwr_ctl_type;

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic mcs_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [IDX_W-1:0]  idx);
      return addr[ADDR_W-1:2] == idx;
   endfunction

   function automatic logic [31:0] mcs_sum32(input logic [31:0] a,
                                             input logic [31:0] b,
                                             input logic [31:0] c);
      return a + b + c;
   endfunction

endpackage

/* File: mcs_regs.sv */
// metering control/status registers behind an APB slave
// assumes mode pulses and samples come from logic on ref_clk; the
// voltage polarity comes from an analog comparator pin
//
// Summary of operation
// - checksum sum all ones clears config error
// - run of samples above threshold sets flag
// - flag clears by writing 0 while below
// - sign bit follows voltage polarity, 1 negative
// - reset sources restore analog control defaults
// - analog control register readable and writable
// - clearing rc powerdown bit enables rc clock
// - sleep sets rc powerdown, detect mode clears
// - bias enable powers bias, resets disabled
// - bandgap enable powers reference, resets disabled
// - sleep clears bias/bandgap, detect mode sets them
// - voltage adc enable turns converter on
// - sleep or detect mode clears voltage adc
// - self-check error zero only on exact inverse
`timescale 1ns/1ps
module mcs_regs
   import mcs_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   input  wire mcs_apb_req_type   apb_req,
   output mcs_apb_rsp_type        apb_rsp,
   input  wire logic              rx_reset_req,
   input  wire logic              soft_reset_req,
   input  wire logic              sleep_enter,
   input  wire logic              detect_mode_enter,
   input  wire logic              cur_sample_valid,
   input  wire logic [15:0]       cur_sample,
   input  wire logic              voltage_negative_pin,
   input  wire logic [31:0]       cfg_sum_other,
   output mcs_pwr_ctl_type        pwr_ctl,
   output logic                   irq
);

   typedef struct packed {
      logic [31:0]      system_control_status;
      logic [31:0]      ana0;
      logic [31:0]      checksum;
      logic [31:0]      detcfg;
      logic             detect;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_en;
      logic             chk_prev;
      logic             sys_prev;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
      logic             irq;
   } mcs_main_state_type;

   localparam mcs_main_state_type MAIN_RESET = '{
      system_control_status:  SYSTEM_CONTROL_STATUS_RESET,
      ana0:     ANA0_RESET,
      checksum: CHECKSUM_RESET,
      detcfg:   DETCFG_RESET,
      chk_prev: 1'b1,
      sys_prev: 1'b1,
      default:  '0
   };

   mcs_main_state_type st_q;
   mcs_main_state_type st_d;

   logic             sign_lvl;
   logic             det_above;
   logic             det_hit;
   logic             chk_err;
   logic             sys_err;
   logic             setup;
   logic             wr;
   logic             mapped;
   logic             det_clr;
   logic [31:0]      rd_data;
   logic [31:0]      sc_view;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   mcs_pin_sync u_sign_sync (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .pin     (voltage_negative_pin),
      .level   (sign_lvl)
   );

   mcs_run_detect u_run_detect (
      .ref_clk      (ref_clk),
      .reset_n      (reset_n),
      .sample_valid (cur_sample_valid),
      .sample       (cur_sample),
      .threshold    (st_q.detcfg[DET_THR_LSB +: DET_THR_W]),
      .run_len      (st_q.detcfg[DET_RUN_LSB +: DET_RUN_W]),
      .above        (det_above),
      .hit          (det_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // live error flags: no trigger, always reflect the stored words
   always_comb
   begin
      chk_err = mcs_sum32(cfg_sum_other, st_q.ana0, st_q.checksum)
                != CHKSUM_PASS;
      sys_err = st_q.system_control_status[SC_MIRROR_LSB +: SC_FIELD_W]
                != ~st_q.system_control_status[SC_LOW_LSB +: SC_FIELD_W];
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus decode and read view
   always_comb
   begin
      setup  = apb_req.psel & ~apb_req.penable;
      wr     = apb_req.psel & apb_req.penable & st_q.pready & apb_req.pwrite;
      mapped = mcs_hit(apb_req.paddr, IDX_SYSTEM_CONTROL_STATUS)
             | mcs_hit(apb_req.paddr, IDX_ANA0)
             | mcs_hit(apb_req.paddr, IDX_CHECKSUM)
             | mcs_hit(apb_req.paddr, IDX_DETCFG)
             | mcs_hit(apb_req.paddr, IDX_IRQ_STAT)
             | mcs_hit(apb_req.paddr, IDX_IRQ_CLR)
             | mcs_hit(apb_req.paddr, IDX_IRQ_EN);

      // stored mirror bits stay in place for the self-check compare,
      // but reads of these four positions show the live status
      sc_view                = st_q.system_control_status;
      sc_view[SC_SIGN_BIT]   = sign_lvl;
      sc_view[SC_DETECT_BIT] = st_q.detect;
      sc_view[SC_CONFIG_CHECKSUM_ERROR_BIT] = chk_err;
      sc_view[SC_SELFCHECK_ERROR_BIT] = sys_err;

      rd_data = 32'h0;
      if (mcs_hit(apb_req.paddr, IDX_SYSTEM_CONTROL_STATUS))
      begin
         rd_data = sc_view;
      end
      else if (mcs_hit(apb_req.paddr, IDX_ANA0))
      begin
         rd_data = st_q.ana0;
      end
      else if (mcs_hit(apb_req.paddr, IDX_CHECKSUM))
      begin
         rd_data = st_q.checksum;
      end
      else if (mcs_hit(apb_req.paddr, IDX_DETCFG))
      begin
         rd_data = st_q.detcfg;
      end
      else if (mcs_hit(apb_req.paddr, IDX_IRQ_STAT))
      begin
         rd_data = {{(32-IRQ_W){1'b0}}, st_q.irq_stat};
      end
      else if (mcs_hit(apb_req.paddr, IDX_IRQ_EN))
      begin
         rd_data = {{(32-IRQ_W){1'b0}}, st_q.irq_en};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      st_d         = st_q;
      st_d.pready  = setup;
      st_d.pslverr = setup & ~mapped;
      st_d.prdata  = (setup & ~apb_req.pwrite) ? rd_data : 32'h0;

      if (wr && mcs_hit(apb_req.paddr, IDX_SYSTEM_CONTROL_STATUS))
      begin
         st_d.system_control_status = apb_req.pwdata;
      end
      if (wr && mcs_hit(apb_req.paddr, IDX_CHECKSUM))
      begin
         st_d.checksum = apb_req.pwdata;
      end
      if (wr && mcs_hit(apb_req.paddr, IDX_DETCFG))
      begin
         st_d.detcfg = apb_req.pwdata;
      end
      if (wr && mcs_hit(apb_req.paddr, IDX_IRQ_EN))
      begin
         st_d.irq_en = apb_req.pwdata[IRQ_W-1:0];
      end

      // detect flag: only a written 0 while below clears; a new hit wins
      det_clr = wr && mcs_hit(apb_req.paddr, IDX_SYSTEM_CONTROL_STATUS)
                && !apb_req.pwdata[SC_DETECT_BIT] && !det_above;
      st_d.detect = det_hit | (st_q.detect & ~det_clr);

      // analog control 0: software first, then mode entry overrides
      if (wr && mcs_hit(apb_req.paddr, IDX_ANA0))
      begin
         st_d.ana0 = apb_req.pwdata;
      end
      if (sleep_enter)
      begin
         st_d.ana0[ANA_RC_PD_BIT] = 1'b1;
         st_d.ana0[ANA_BIAS_BIT]  = 1'b0;
         st_d.ana0[ANA_BG_BIT]    = 1'b0;
         st_d.ana0[ANA_VADC_BIT]  = 1'b0;
      end
      else if (detect_mode_enter)
      begin
         st_d.ana0[ANA_RC_PD_BIT] = 1'b0;
         st_d.ana0[ANA_BIAS_BIT]  = 1'b1;
         st_d.ana0[ANA_BG_BIT]    = 1'b1;
         st_d.ana0[ANA_VADC_BIT]  = 1'b0;
      end
      if (rx_reset_req || soft_reset_req)
      begin
         st_d.ana0 = ANA0_RESET;
      end

      // interrupts: rising errors and detect hits; set beats clear
      st_d.chk_prev = chk_err;
      st_d.sys_prev = sys_err;
      irq_set       = '0;
      irq_set[IRQ_DETECT_BIT] = det_hit;
      irq_set[IRQ_CONFIG_CHECKSUM_ERROR_BIT] = chk_err & ~st_q.chk_prev;
      irq_set[IRQ_SELFCHECK_ERROR_BIT] = sys_err & ~st_q.sys_prev;
      irq_clr = (wr && mcs_hit(apb_req.paddr, IDX_IRQ_CLR))
                ? apb_req.pwdata[IRQ_W-1:0] : '0;
      st_d.irq_stat = (st_q.irq_stat & ~irq_clr) | irq_set;
      st_d.irq      = |(st_d.irq_stat & st_d.irq_en);
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q <= MAIN_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from the state register
   assign apb_rsp.pready  = st_q.pready;
   assign apb_rsp.pslverr = st_q.pslverr;
   assign apb_rsp.prdata  = st_q.prdata;
   // analog enables drive the bias, reference, rc and adc circuits directly
   assign pwr_ctl.rc_osc_powerdown    = st_q.ana0[ANA_RC_PD_BIT];
   assign pwr_ctl.bias_circuit_enable = st_q.ana0[ANA_BIAS_BIT];
   assign pwr_ctl.bandgap_enable      = st_q.ana0[ANA_BG_BIT];
   assign pwr_ctl.voltage_adc_enable  = st_q.ana0[ANA_VADC_BIT];
   assign irq = st_q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   a_chk_read: assert property (
      setup && !apb_req.pwrite && mcs_hit(apb_req.paddr, IDX_SYSTEM_CONTROL_STATUS)
      |=> apb_rsp.prdata[SC_CONFIG_CHECKSUM_ERROR_BIT] == $past(chk_err))
      else $error("config error bit read wrong");

   a_detect_set: assert property (
      det_hit |=> st_q.detect ##1 st_q.detect || $past(det_clr))
      else $error("detect flag not set by run");

   a_detect_hold: assert property (
      st_q.detect && !det_clr |=> st_q.detect)
      else $error("detect flag cleared without valid write");

   a_sign_read: assert property (
      setup && !apb_req.pwrite && mcs_hit(apb_req.paddr, IDX_SYSTEM_CONTROL_STATUS)
      |=> apb_rsp.prdata[SC_SIGN_BIT] == $past(sign_lvl))
      else $error("sign bit read does not match polarity");

   a_reset_ana: assert property (
      rx_reset_req || soft_reset_req |=> st_q.ana0 == ANA0_RESET)
      else $error("analog control not restored");

   a_ana_write: assert property (
      wr && mcs_hit(apb_req.paddr, IDX_ANA0) && !sleep_enter
      && !detect_mode_enter && !rx_reset_req && !soft_reset_req
      |=> st_q.ana0 == $past(apb_req.pwdata))
      else $error("analog control write lost");

   a_sleep_pwr: assert property (
      sleep_enter && !rx_reset_req && !soft_reset_req
      |=> pwr_ctl.rc_osc_powerdown && !pwr_ctl.bias_circuit_enable
          && !pwr_ctl.bandgap_enable && !pwr_ctl.voltage_adc_enable)
      else $error("sleep entry power bits wrong");

   a_detmode_pwr: assert property (
      detect_mode_enter && !sleep_enter && !rx_reset_req && !soft_reset_req
      |=> !pwr_ctl.rc_osc_powerdown && pwr_ctl.bias_circuit_enable
          && pwr_ctl.bandgap_enable && !pwr_ctl.voltage_adc_enable)
      else $error("detect mode power bits wrong");

   a_selfcheck_read: assert property (
      setup && !apb_req.pwrite && mcs_hit(apb_req.paddr, IDX_SYSTEM_CONTROL_STATUS)
      |=> apb_rsp.prdata[SC_SELFCHECK_ERROR_BIT] == $past(sys_err))
      else $error("self-check bit read wrong");

endmodule

/* File: mcs_run_detect.sv */
// counts consecutive current samples above a threshold
// assumes samples and settings arrive on ref_clk from the metering path
`timescale 1ns/1ps
module mcs_run_detect
   import mcs_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic                 reset_n,
   input  wire logic                 sample_valid,
   input  wire logic [DET_THR_W-1:0] sample,
   input  wire logic [DET_THR_W-1:0] threshold,
   input  wire logic [DET_RUN_W-1:0] run_len,
   output logic                      above,
   output logic                      hit
);

   typedef struct packed {
      logic [DET_RUN_W-1:0] cnt;
      logic                 above;
      logic                 hit;
   } mcs_det_state_type;

   mcs_det_state_type   st_q;
   mcs_det_state_type   st_d;
   logic [DET_RUN_W-1:0] need;
   logic [DET_RUN_W-1:0] cnt_inc;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      st_d     = st_q;
      st_d.hit = 1'b0;
      // a zero length would fire on every sample after the count saturates; treat it as one sample
      need     = (run_len == '0) ? DET_RUN_W'(1) : run_len;
      cnt_inc  = DET_RUN_W'(st_q.cnt + DET_RUN_W'(1));
      if (sample_valid)
      begin
         if (sample > threshold)
         begin
            st_d.above = 1'b1;
            // saturate so a long run fires exactly once
            if (st_q.cnt != '1)
            begin
               st_d.cnt = cnt_inc;
            end
            st_d.hit = (cnt_inc == need);
         end
         else
         begin
            st_d.above = 1'b0;
            st_d.cnt   = '0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign above = st_q.above;
   assign hit   = st_q.hit;

endmodule

/* File: tb_top.sv */
// self-checking bench for the metering control/status register block
// assumes mcs_pkg and mcs_regs compiled first; drives APB and side inputs
`timescale 1ns/1ps
module tb_top
   import mcs_pkg::*;
;
   logic            ref_clk;
   logic            reset_n;
   mcs_apb_req_type req;
   mcs_apb_rsp_type rsp;
   logic            rx_rst;
   logic            sw_rst;
   logic            sleep_in;
   logic            det_in;
   logic            smp_v;
   logic [15:0]     smp;
   logic            vneg;
   logic [31:0]     sum_other;
   mcs_pwr_ctl_type pwr;
   logic            irq;
   int              err_total;
   int              n_checks;
   int              seed;
   logic [31:0]     m_ana;
   logic [31:0]     r;
   logic [31:0]     v;
   logic            e;

   mcs_regs mcs_regs_i
   (
      .ref_clk              (ref_clk),
      .reset_n              (reset_n),
      .apb_req              (req),
      .apb_rsp              (rsp),
      .rx_reset_req         (rx_rst),
      .soft_reset_req       (sw_rst),
      .sleep_enter          (sleep_in),
      .detect_mode_enter    (det_in),
      .cur_sample_valid     (smp_v),
      .cur_sample           (smp),
      .voltage_negative_pin (vneg),
      .cfg_sum_other        (sum_other),
      .pwr_ctl              (pwr),
      .irq                  (irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic chk(input string nm, input logic [31:0] got,
                      input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [IDX_W-1:0] idx,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= wr;
      req.paddr   <= {idx, 2'b00};
      req.pwdata  <= d;
      @(posedge ref_clk);
      req.penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (rsp.pready !== 1'b1 && n < 50);
      if (n >= 50)
         chk("pready", 32'h0, 32'h1);
      r = rsp.prdata;
      e = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic sample(input logic [15:0] s);
      @(posedge ref_clk);
      smp_v <= 1'b1;
      smp   <= s;
      @(posedge ref_clk);
      smp_v <= 1'b0;
   endtask

   task automatic pulse(input int k);
      @(posedge ref_clk);
      rx_rst   <= (k == 0);
      sw_rst   <= (k == 1);
      sleep_in <= (k == 2);
      det_in   <= (k == 3);
      @(posedge ref_clk);
      {rx_rst, sw_rst, sleep_in, det_in} <= 4'h0;
   endtask

   task automatic ana_chk();
      apb(1'b0, IDX_ANA0, 32'h0);
      chk("ana0", r, m_ana);
      chk("pwr", {28'h0, pwr}, {28'h0, m_ana[29:26]});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      give_verdict();
   end

   initial
   begin
      err_total = 0;
      n_checks  = 0;
      seed      = 93363;
      reset_n   = 1'b0;
      req       = '0;
      {rx_rst, sw_rst, sleep_in, det_in, smp_v} = 5'h0;
      smp       = 16'h0;
      vneg      = 1'b0;
      sum_other = 32'h0;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      m_ana = ANA0_RESET;
      ana_chk();
      // reset sources, then mode entries, each from a random setting
      for (int k = 0; k < 4; k++)
      begin
         v = $random(seed);
         m_ana = {2'b11, v[29:0]};
         apb(1'b1, IDX_ANA0, m_ana);
         ana_chk();
         pulse(k);
         if (k < 2)
            m_ana = ANA0_RESET;
         else
            m_ana = (m_ana & 32'hc3ff_ffff)
                  | ((k == 2) ? 32'h2000_0000 : 32'h1800_0000);
         ana_chk();
      end
      $display("test power control done");
      // voltage sign follows pin after sync delay
      for (int k = 1; k >= 0; k--)
      begin
         @(posedge ref_clk);
         vneg <= k[0];
         repeat (6) @(posedge ref_clk);
         apb(1'b0, IDX_SYSTEM_CONTROL_STATUS, 32'h0);
         chk("sign", {31'h0, r[SC_SIGN_BIT]}, k);
      end
      $display("test sign done");
      // self-check: exact inverse passes, one flipped bit fails
      apb(1'b1, IDX_SYSTEM_CONTROL_STATUS, {7'h0, ~9'h0a5, 7'h0, 9'h0a5});
      apb(1'b0, IDX_SYSTEM_CONTROL_STATUS, 32'h0);
      chk("selfchk", {31'h0, r[SC_SELFCHECK_ERROR_BIT]}, 32'h0);
      apb(1'b1, IDX_SYSTEM_CONTROL_STATUS, {7'h0, ~9'h0a4, 7'h0, 9'h0a5});
      apb(1'b0, IDX_SYSTEM_CONTROL_STATUS, 32'h0);
      chk("selfchk", {31'h0, r[SC_SELFCHECK_ERROR_BIT]}, 32'h1);
      $display("test self-check done");
      // checksum against a random outside sum
      @(posedge ref_clk);
      sum_other <= $random(seed);
      @(posedge ref_clk);
      v = CHKSUM_PASS - sum_other - m_ana;
      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, IDX_CHECKSUM, v + k);
         apb(1'b0, IDX_SYSTEM_CONTROL_STATUS, 32'h0);
         chk("config_checksum_error", {31'h0, r[SC_CONFIG_CHECKSUM_ERROR_BIT]}, k);
      end
      $display("test checksum done");
      // detector: three above is short of the default run of four
      // both error flags have risen once by now, no detector hit yet
      apb(1'b0, IDX_IRQ_STAT, 32'h0);
      chk("irqstat", r, 32'h6);
      apb(1'b1, IDX_IRQ_CLR, 32'h7);
      apb(1'b1, IDX_IRQ_EN, 32'h1);
      repeat (3) sample(16'h0101);
      sample(16'h0100);
      apb(1'b0, IDX_SYSTEM_CONTROL_STATUS, 32'h0);
      chk("detect", {31'h0, r[SC_DETECT_BIT]}, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
      repeat (4) sample(16'hffff);
      apb(1'b0, IDX_SYSTEM_CONTROL_STATUS, 32'h0);
      chk("detect", {31'h0, r[SC_DETECT_BIT]}, 32'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      // clear refused while last sample above, accepted once below
      apb(1'b1, IDX_SYSTEM_CONTROL_STATUS, 32'h0);
      apb(1'b0, IDX_SYSTEM_CONTROL_STATUS, 32'h0);
      chk("detect", {31'h0, r[SC_DETECT_BIT]}, 32'h1);
      sample(16'h0000);
      apb(1'b1, IDX_SYSTEM_CONTROL_STATUS, 32'h0);
      apb(1'b0, IDX_SYSTEM_CONTROL_STATUS, 32'h0);
      chk("detect", {31'h0, r[SC_DETECT_BIT]}, 32'h0);
      apb(1'b1, IDX_IRQ_CLR, 32'h1);
      // irq moves at the access edge; look one edge later
      @(posedge ref_clk);
      chk("irq", {31'h0, irq}, 32'h0);
      // masked hit keeps status but no interrupt
      apb(1'b1, IDX_IRQ_EN, 32'h0);
      repeat (4) sample(16'h0200);
      apb(1'b0, IDX_IRQ_STAT, 32'h0);
      chk("irqstat", {31'h0, r[IRQ_DETECT_BIT]}, 32'h1);
      chk("irq", {31'h0, irq}, 32'h0);
      apb(1'b1, IDX_IRQ_EN, 32'h1);
      @(posedge ref_clk);
      chk("irq", {31'h0, irq}, 32'h1);
      $display("test detector done");
      // unmapped index refused, clear register reads zero
      apb(1'b1, 10'h001, 32'h1234_5678);
      chk("slverr", {31'h0, e}, 32'h1);
      apb(1'b0, 10'h001, 32'h0);
      chk("unmapped", r, 32'h0);
      apb(1'b0, IDX_IRQ_CLR, 32'h0);
      chk("clrread", {r[30:0], e}, 32'h0);
      ana_chk();
      // metering bring-up: bias and bandgap first, rc kept off, then adc
      m_ana = 32'hf800_0000;
      apb(1'b1, IDX_ANA0, m_ana);
      ana_chk();
      m_ana = 32'hfc00_0000;
      apb(1'b1, IDX_ANA0, m_ana);
      ana_chk();
      $display("test bus done");
      give_verdict();
   end
endmodule
